// [core/frd_pkg.sv]
// Shared constants for the fault restart sequencer
package frd_pkg;
	// ==========================================
	// Command codes
	localparam logic [7:0] CODE_UV_RESPONSE = 8'h45;
	localparam logic [7:0] CODE_OC_LIMIT = 8'h46;
	localparam logic [7:0] CODE_TIME_UNIT = 8'hD2;
	localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CODE_FAULT_STATUS = 8'h7A;
	// ==========================================
	// Response byte fields
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_RUN_DELAY = 2'h1;
	localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
	localparam logic [1:0] MODE_DISABLE_HOLD = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// ==========================================
	// Status word fields
	localparam int STS_FAULT = 0;
	localparam int STS_GAVE_UP = 1;
	localparam int STS_CNT_LO = 2;
	localparam int STS_CNT_HI = 4;
	// ==========================================
	// Reset values and timing
	localparam logic [7:0] UV_RESPONSE_RESET = 8'h80;
	localparam logic [15:0] OC_LIMIT_RESET = 16'h0000;
	localparam int CLK_MHZ = 10;
	localparam int TIME_UNIT_US = 1000;
	localparam int TIME_UNIT_CYCLES = TIME_UNIT_US * CLK_MHZ;
	localparam logic [15:0] TIME_UNIT_RESET = 16'(TIME_UNIT_CYCLES);
endpackage

// [core/frd_delay_timer.sv]
// Delay timer counting two to the power of a field, in programmable time units
`timescale 1ns/1ps
module frd_delay_timer #(
	parameter int UW = 16
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic [2:0] exp_sel,
	input wire logic [UW-1:0] unit_len,
	// Result
	output logic done
);
	// ==========================================
	// Decode
	logic [UW-1:0] pre_r;
	logic [7:0] units_r;
	logic run_r;
	logic done_r;
	wire [UW-1:0] unit_m1 = (unit_len == '0) ? '0 : unit_len - UW'(1);
	wire [7:0] span = 8'h01 << exp_sel; // RULE_05
	wire [7:0] last_unit = span - 8'h01;
	wire tick = run_r && (pre_r == unit_m1); // RULE_04
	assign done = done_r;
	// ==========================================
	// Counters
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_r <= '0;
			units_r <= 8'h00;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end
		else if (start)
		begin
			pre_r <= '0;
			units_r <= 8'h00;
			run_r <= 1'b1;
			done_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			if (tick)
			begin
				pre_r <= '0;
				units_r <= units_r + 8'h01;
				if (units_r == last_unit)
				begin
					run_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
			else if (run_r)
				pre_r <= pre_r + UW'(1);
		end
	end
endmodule

// [core/frd_top.sv]
// Output under-voltage fault restart sequencer with its command registers
`timescale 1ns/1ps
// How it works
// (RULE_01) Retry values one to six give exactly that many restart attempts before giving up.
// (RULE_02) After the last permitted attempt fails the output is disabled until the fault clears.
// (RULE_03) Retry value seven restarts without limit until turned off, bias is lost or another stop.
// (RULE_04) Attempt starts are spaced by the delay count times the configured time unit.
// (RULE_05) The delay field selects two to the power of its value in time units, 1 up to 128.
// (RULE_06) The same delay is the run-on time after a fault or the spacing of restart attempts.
// (RULE_07) The length of one time unit is held in the register at code 0xD2.
// (RULE_08) The over-current limit is a 16-bit host read/write word at code 0x46.
// (RULE_09) Response code 10 disables the output at once and then follows the retry setting.
// (RULE_10) Response code 01 runs on for the delay and follows the retry setting if the fault stays.
// (RULE_11) Retry value zero makes no restart and keeps the output off until the fault clears.
// (RULE_12) A latched fault clears by clear command, its status bit, an off-on cycle or bias loss.
// (RULE_13) Clearing the fault or turning off resets the attempt counter and the delay timer; a clear in ST_HOLD resets neither.
module frd_top #(
	parameter logic [7:0] UV_RESPONSE_INIT = frd_pkg::UV_RESPONSE_RESET,
	parameter logic [15:0] OC_LIMIT_INIT = frd_pkg::OC_LIMIT_RESET,
	parameter logic [15:0] TIME_UNIT_INIT = frd_pkg::TIME_UNIT_RESET
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Command register port
	input wire logic [7:0] CMD_CODE,
	input wire logic WR_STB,
	input wire logic [15:0] WR_DATA,
	output logic [15:0] RD_DATA,
	// Pins
	input wire logic UV_FAULT,
	input wire logic CTRL_ON,
	input wire logic BIAS_OK,
	// Converter control
	output logic OUTPUT_EN,
	output logic FAULT_LATCHED
);
	typedef enum logic [2:0] {
		ST_OFF, ST_RUN, ST_GRACE, ST_WAIT, ST_TRY, ST_TRYOFF, ST_LATCH, ST_HOLD
	} frd_state_e;
	// ==========================================
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_r;
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	wire rst_n = rst_sync_r[1];
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
		end
		else
		begin
			pin_s1_r <= {BIAS_OK, CTRL_ON, UV_FAULT};
			pin_s2_r <= pin_s1_r;
		end
	end
	wire fault = pin_s2_r[0];
	wire ctrl_on = pin_s2_r[1];
	wire bias_ok = pin_s2_r[2];
	// ==========================================
	// Registers and decode
	logic [7:0] rsp_r;
	logic [15:0] oc_limit_r;
	logic [15:0] unit_r;
	logic sts_fault_r;
	logic ctrl_d_r;
	logic fault_d_r;
	logic [15:0] rd_data_r;
	frd_state_e state_r, state_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic out_r, out_nxt;
	logic tmr_start;
	logic tmr_done;
	wire wr_rsp = WR_STB && (CMD_CODE == frd_pkg::CODE_UV_RESPONSE);
	wire wr_oc = WR_STB && (CMD_CODE == frd_pkg::CODE_OC_LIMIT);
	wire wr_unit = WR_STB && (CMD_CODE == frd_pkg::CODE_TIME_UNIT);
	wire wr_clear = WR_STB && (CMD_CODE == frd_pkg::CODE_CLEAR_FAULTS);
	wire wr_sts = WR_STB && (CMD_CODE == frd_pkg::CODE_FAULT_STATUS);
	wire [1:0] mode = rsp_r[frd_pkg::MODE_HI:frd_pkg::MODE_LO];
	wire [2:0] retries = rsp_r[frd_pkg::RETRY_HI:frd_pkg::RETRY_LO];
	wire [2:0] dly = rsp_r[frd_pkg::DELAY_HI:frd_pkg::DELAY_LO];
	wire on_cmd = ctrl_on && bias_ok;
	// Off-then-on through the pin, the clear command, the status bit or bias loss
	wire clr_evt = wr_clear || (wr_sts && WR_DATA[frd_pkg::STS_FAULT]) ||
		(ctrl_on && !ctrl_d_r) || !bias_ok; // RULE_12
	wire fault_rise = fault && !fault_d_r;
	wire forever_mode = (retries == frd_pkg::RETRY_FOREVER); // RULE_03
	wire exhausted = !forever_mode && (cnt_r >= retries); // RULE_01
	wire [2:0] cnt_inc = forever_mode ? cnt_r : cnt_r + 3'h1;
	wire gave_up = (state_r == ST_LATCH);
	wire [15:0] sts_word = {11'h000, cnt_r, gave_up, sts_fault_r};
	wire [15:0] rd_mux = (CMD_CODE == frd_pkg::CODE_UV_RESPONSE) ? {8'h00, rsp_r} :
		(CMD_CODE == frd_pkg::CODE_OC_LIMIT) ? oc_limit_r : // RULE_08
		(CMD_CODE == frd_pkg::CODE_TIME_UNIT) ? unit_r :
		(CMD_CODE == frd_pkg::CODE_FAULT_STATUS) ? sts_word : 16'h0000;
	assign RD_DATA = rd_data_r;
	assign OUTPUT_EN = out_r;
	assign FAULT_LATCHED = sts_fault_r;
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_r <= UV_RESPONSE_INIT;
			oc_limit_r <= OC_LIMIT_INIT;
			unit_r <= TIME_UNIT_INIT;
			rd_data_r <= 16'h0000;
		end
		else
		begin
			if (wr_rsp)
				rsp_r <= WR_DATA[7:0];
			if (wr_oc)
				oc_limit_r <= WR_DATA; // RULE_08
			if (wr_unit)
				unit_r <= WR_DATA; // RULE_07
			rd_data_r <= rd_mux;
		end
	end
	// A new fault edge wins over a clear in the same cycle
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sts_fault_r <= 1'b0;
			ctrl_d_r <= 1'b0;
			fault_d_r <= 1'b0;
		end
		else
		begin
			ctrl_d_r <= ctrl_on;
			fault_d_r <= fault;
			if (fault_rise)
				sts_fault_r <= 1'b1;
			else if (clr_evt)
				sts_fault_r <= 1'b0; // RULE_12
		end
	end
	// ==========================================
	// Restart sequencer
	frd_delay_timer #(
		.UW(16)
	) u_timer (
		.clk(CLK),
		.rst_n(rst_n),
		.start(tmr_start),
		.exp_sel(dly),
		.unit_len(unit_r),
		.done(tmr_done)
	);
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		tmr_start = 1'b0;
		if (!on_cmd)
		begin
			// Commanded off or bias gone: stop and forget the sequence
			state_nxt = ST_OFF; // RULE_03
			out_nxt = 1'b0;
			cnt_nxt = 3'h0; // RULE_13
			tmr_start = 1'b1;
		end
		else if (clr_evt && (state_r != ST_HOLD))
		begin
			state_nxt = ST_RUN; // RULE_12
			out_nxt = 1'b1;
			cnt_nxt = 3'h0; // RULE_13
			tmr_start = 1'b1;
		end
		else
		begin
			case (state_r)
				ST_OFF:
				begin
					state_nxt = ST_RUN;
					out_nxt = 1'b1;
					cnt_nxt = 3'h0;
				end
				ST_RUN:
				begin
					if (fault && (mode == frd_pkg::MODE_RUN_DELAY))
					begin
						state_nxt = ST_GRACE; // RULE_10
						tmr_start = 1'b1; // RULE_06
					end
					else if (fault && (mode == frd_pkg::MODE_DISABLE_RETRY))
					begin
						out_nxt = 1'b0; // RULE_09
						tmr_start = 1'b1;
						state_nxt = (retries == frd_pkg::RETRY_NONE) ? ST_LATCH : ST_WAIT; // RULE_11
					end
					else if (fault && (mode == frd_pkg::MODE_DISABLE_HOLD))
					begin
						out_nxt = 1'b0;
						state_nxt = ST_HOLD;
					end
				end
				ST_GRACE:
				begin
					if (tmr_done && fault)
					begin
						out_nxt = 1'b0; // RULE_10
						tmr_start = 1'b1;
						state_nxt = (retries == frd_pkg::RETRY_NONE) ? ST_LATCH : ST_WAIT; // RULE_11
					end
					else if (tmr_done)
						state_nxt = ST_RUN;
				end
				ST_WAIT, ST_TRYOFF:
				begin
					if (tmr_done)
					begin
						// Each attempt start reloads the timer, fixing the spacing
						state_nxt = ST_TRY; // RULE_04
						out_nxt = 1'b1;
						tmr_start = 1'b1; // RULE_06
						cnt_nxt = cnt_inc; // RULE_01
					end
				end
				ST_TRY:
				begin
					if (fault)
					begin
						out_nxt = 1'b0;
						state_nxt = exhausted ? ST_LATCH : ST_TRYOFF; // RULE_02
					end
					else if (tmr_done)
					begin
						state_nxt = ST_RUN;
						cnt_nxt = 3'h0;
					end
				end
				ST_LATCH:
					out_nxt = 1'b0; // RULE_02
				ST_HOLD:
				begin
					if (!fault)
					begin
						state_nxt = ST_RUN;
						out_nxt = 1'b1;
					end
				end
				default:
					state_nxt = ST_OFF;
			endcase
		end
	end
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_OFF;
			cnt_r <= 3'h0;
			out_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end
endmodule

// [sim/frd_host.sv]
// Host model that programs the command registers
`timescale 1ns/1ps
module frd_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] cmd,
	output logic stb,
	output logic [15:0] wdat,
	input wire logic [15:0] rdat
);
	initial
	begin
		cmd = 8'h00;
		stb = 1'b0;
		wdat = 16'h0000;
	end
	// Whole word per strobe; data is inverted once released
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
	begin
		@(posedge clk);
		#10;
		cmd = c;
		wdat = v;
		stb = 1'b1;
		@(posedge clk);
		#10;
		stb = 1'b0;
		wdat = ~v;
	end
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] v);
	begin
		@(posedge clk);
		#10;
		cmd = c;
		@(posedge clk);
		#10;
		v = rdat;
	end
	endtask
endmodule

// [sim/frd_top_properties.sv]
// Port checks for the fault restart sequencer
`timescale 1ns/1ps
module frd_checker #(
	parameter logic [7:0] UV_RESPONSE_INIT = frd_pkg::UV_RESPONSE_RESET
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Register port
	input wire logic [7:0] CMD_CODE,
	input wire logic WR_STB,
	input wire logic [15:0] WR_DATA,
	input wire logic [15:0] RD_DATA,
	// Pins
	input wire logic UV_FAULT,
	input wire logic CTRL_ON,
	input wire logic BIAS_OK,
	input wire logic OUTPUT_EN,
	input wire logic FAULT_LATCHED
);
	// ====
	// Shadow of the response byte, rebuilt from writes
	logic [7:0] resp_r;
	logic [1:0] mode;
	logic [2:0] tries;
	assign mode = resp_r[7:6];
	assign tries = resp_r[5:3];
	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
			resp_r <= UV_RESPONSE_INIT;
		else if (WR_STB && CMD_CODE == 8'h45)
			resp_r <= WR_DATA[7:0];
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	property p_oc;
		WR_STB && CMD_CODE == 8'h46 ##1 CMD_CODE == 8'h46 |=> RD_DATA == $past(WR_DATA, 2);
	endproperty
	a_oc: assert property (p_oc) else $error("limit readback wrong");
	property p_bias;
		!BIAS_OK [*6] |-> !OUTPUT_EN;
	endproperty
	a_bias: assert property (p_bias) else $error("on without bias");
	property p_ctrl;
		!CTRL_ON [*6] |-> !OUTPUT_EN;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("on while commanded off");
	property p_m10;
		$rose(UV_FAULT) && mode == 2'h2 && OUTPUT_EN |-> ##[1:5] !OUTPUT_EN;
	endproperty
	a_m10: assert property (p_m10) else $error("no prompt shutdown");
	property p_m01;
		$rose(UV_FAULT) && mode == 2'h1 && tries == 3'h0 && OUTPUT_EN |=> OUTPUT_EN [*3];
	endproperty
	a_m01: assert property (p_m01) else $error("no run-on");
	property p_none;
		mode == 2'h2 && tries == 3'h0 && $fell(OUTPUT_EN) |=> !OUTPUT_EN [*8];
	endproperty
	a_none: assert property (p_none) else $error("restart with no retries");
	property p_latch;
		$rose(UV_FAULT) && mode != 2'h0 |-> ##[1:5] FAULT_LATCHED;
	endproperty
	a_latch: assert property (p_latch) else $error("fault not latched");
	property p_clear;
		!UV_FAULT [*4] ##0 WR_STB && CMD_CODE == 8'h03 |-> ##[1:3] !FAULT_LATCHED;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");
	property p_hold;
		$rose(UV_FAULT) && mode == 2'h3 |-> ##[1:5] !OUTPUT_EN;
	endproperty
	a_hold: assert property (p_hold) else $error("output on during held fault");
	c_retry: cover property ($rose(OUTPUT_EN) && UV_FAULT);
	c_clear: cover property ($fell(FAULT_LATCHED));
	c_run_on: cover property (mode == 2'h1 && $fell(OUTPUT_EN));
endmodule
bind frd_top frd_checker #(.UV_RESPONSE_INIT(UV_RESPONSE_INIT)) u_chk (.CLK(CLK),
	.RESETN(RESETN), .CMD_CODE(CMD_CODE), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
	.RD_DATA(RD_DATA), .UV_FAULT(UV_FAULT), .CTRL_ON(CTRL_ON), .BIAS_OK(BIAS_OK),
	.OUTPUT_EN(OUTPUT_EN), .FAULT_LATCHED(FAULT_LATCHED));

// [sim/test_fault_retry_delay_control.sv]
// Self-checking bench for the fault restart sequencer
`timescale 1ns/1ps
module test_fault_retry_delay_control;
	localparam logic [15:0] UNIT = 16'h0004;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic uv = 1'b0;
	logic on = 1'b0;
	logic bias = 1'b0;
	logic [7:0] cmd;
	logic stb;
	logic [15:0] wdat;
	logic [15:0] rdat;
	logic en;
	logic lat;
	logic pe;
	logic [15:0] d;
	logic [2:0] e;
	int err_total = 0;
	int num_checks = 0;
	int n;
	int t0;
	int gap;
	always #50 clk = ~clk;
	frd_top dut (.CLK(clk), .RESETN(rst_n), .CMD_CODE(cmd), .WR_STB(stb), .WR_DATA(wdat),
		.RD_DATA(rdat), .UV_FAULT(uv), .CTRL_ON(on), .BIAS_OK(bias), .OUTPUT_EN(en),
		.FAULT_LATCHED(lat));
	frd_host host (.clk(clk), .cmd(cmd), .stb(stb), .wdat(wdat), .rdat(rdat));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
	begin
		num_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, want);
		end
	end
	endtask
	task automatic complete_run;
	begin
		if (err_total == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task automatic cyc(input int k);
	begin
		repeat (k) @(posedge clk);
		#10;
	end
	endtask
	// Attempt spacing in cycles; the timer may add a few cycles of overhead
	function automatic logic [15:0] span_ok(input int g);
		return 16'(g >= (1 << e) * UNIT && g <= (1 << e) * UNIT + 4);
	endfunction
	// Hold the fault and count attempt starts and the first spacing
	task automatic episode(input logic [7:0] resp, input int w);
	begin
		host.wr(8'h45, {8'h00, resp});
		host.wr(8'h03, 16'h0000);
		cyc(8);
		uv = 1'b1;
		n = 0;
		gap = 0;
		t0 = 0;
		pe = en;
		for (int i = 0; i < w; i++)
		begin
			cyc(1);
			if (en && !pe)
			begin
				n++;
				if (n == 1)
					t0 = i;
				if (n == 2)
					gap = i - t0;
			end
			pe = en;
		end
	end
	endtask
	// Each way of clearing in turn
	task automatic recover(input int k);
	begin
		uv = 1'b0;
		cyc(4);
		case (k % 4)
			0: host.wr(8'h03, 16'h0000);
			1: host.wr(8'h7A, 16'h0001);
			2: begin on = 1'b0; cyc(8); on = 1'b1; end
			default: begin bias = 1'b0; cyc(8); bias = 1'b1; end
		endcase
		cyc(12);
		check(16'(lat), 16'h0000);
		check(16'(en), 16'h0001);
	end
	endtask
	initial
	begin
		n = $urandom(1);
		cyc(12);
		rst_n = 1'b1;
		cyc(6);
		host.rd(8'hD2, d);
		check(d, frd_pkg::TIME_UNIT_RESET);
		host.rd(8'h10, d);
		check(d, 16'h0000);
		repeat (6)
		begin
			t0 = $urandom;
			host.wr(8'h46, 16'(t0));
			host.rd(8'h46, d);
			check(d, 16'(t0));
		end
		host.wr(8'hD2, UNIT);
		host.rd(8'hD2, d);
		check(d, UNIT);
		on = 1'b1;
		bias = 1'b1;
		cyc(10);
		for (int r = 0; r < 7; r++)
		begin
			e = 3'($urandom_range(0, 3));
			episode({2'h2, 3'(r), e}, 300);
			check(16'(n), 16'(r));
			check(16'(!en && lat), 16'h0001);
			host.rd(8'h7A, d);
			check(d, 16'((r << 2) | 3));
			if (r >= 2)
				check(span_ok(gap), 16'h0001);
			recover(r);
		end
		host.wr(8'h45, 16'h0052);
		host.rd(8'h45, d);
		check(d, 16'h0052);
		uv = 1'b1;
		cyc(5);
		uv = 1'b0;
		cyc(30);
		check(16'(en), 16'h0001);
		episode(8'h42, 60);
		check(16'(en || n != 0), 16'h0000);
		recover(1);
		// Hold mode: off while the fault stands, back on once it goes
		host.wr(8'h45, 16'h00C0);
		uv = 1'b1;
		cyc(8);
		check(16'(en), 16'h0000);
		uv = 1'b0;
		cyc(8);
		check(16'(en), 16'h0001);
		// Ignore mode: the output rides through the fault
		host.wr(8'h45, 16'h0000);
		uv = 1'b1;
		cyc(20);
		check(16'(en), 16'h0001);
		uv = 1'b0;
		cyc(4);
		e = 3'h7;
		episode(8'hBF, 1100);
		check(16'(n >= 2), 16'h0001);
		check(span_ok(gap), 16'h0001);
		on = 1'b0;
		cyc(10);
		check(16'(en), 16'h0000);
		uv = 1'b0;
		on = 1'b1;
		cyc(10);
		check(16'(en), 16'h0001);
		check(16'(lat), 16'h0000);
		complete_run;
	end
	initial
	begin
		#800000;
		err_total++;
		complete_run;
	end
endmodule
